// ===== core/palette_and_compressed_texel_decoder.v
// texel unpack: plain, intensity, luminance, palette and compressed-block texels
// assumes requests and palette loads come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "texel_decoder_defs.vh"
module palette_and_compressed_texel_decoder #(
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter PAL_DEPTH  = `PAL_DEPTH
) (
	input  wire                      clock,
	input  wire                      reset,
	input  wire                      reqValid,
	output reg                       reqReady,
	input  wire [`FMT_W-1:0]         reqFormat,
	input  wire                      reqIsDest,
	input  wire [`TEXEL_IDX_W-1:0]   reqTexel,
	input  wire [`BLOCK_W-1:0]       reqData,
	input  wire                      palWrite,
	input  wire [`PAL_ADDR_W-1:0]    palAddr,
	input  wire [`ARGB_W-1:0]        palData,
	output reg                       outValid,
	input  wire                      outReady,
	output reg  [`ARGB_W-1:0]        outColor,
	output reg  [`MODE_W-1:0]        outMode,
	output reg                       outNeedsExt,
	output reg                       outError
);
	localparam ENTRY_W = `ARGB_W + `MODE_W + 2;
	localparam integer READY_LEVEL_INT = FIFO_DEPTH - `READY_MARGIN;
	localparam [`FIFO_ADDR_W:0] READY_LEVEL_MAX = READY_LEVEL_INT[`FIFO_ADDR_W:0];

	// request stage
	reg                      stValid_q;
	reg [`FMT_W-1:0]         stFormat_q;
	reg                      stDest_q;
	reg [`TEXEL_IDX_W-1:0]   stTexel_q;
	reg [`BLOCK_W-1:0]       stData_q;

	wire                     take;
	wire                     fifoInReady;
	wire                     fifoOutValid;
	wire                     fifoOutReady;
	wire [ENTRY_W-1:0]       fifoOutData;
	wire [`FIFO_ADDR_W:0]    fifoLevel;
	wire [ENTRY_W-1:0]       fifoInData;
	wire                     stPush;

	// byte lanes of the stored pixel, byte 0 at the lowest address
	wire [`BYTE_W-1:0]       byte0;
	wire [`BYTE_W-1:0]       byte1;
	wire [`BYTE_W-1:0]       byte2;
	wire [`BYTE_W-1:0]       byte3;
	wire [`NIB_W-1:0]        nibLo;
	wire [`NIB_W-1:0]        nibHi;

	assign byte0 = stData_q[`BYTE0_LO +: `BYTE_W];
	assign byte1 = stData_q[`BYTE1_LO +: `BYTE_W];
	assign byte2 = stData_q[`BYTE2_LO +: `BYTE_W];
	assign byte3 = stData_q[`BYTE3_LO +: `BYTE_W];
	assign nibLo = byte0[`NIB_W-1:0];
	assign nibHi = byte0[`NIB_HI_LO +: `NIB_W];

	// palette lookup
	reg  [`PAL_ADDR_W-1:0]   palIndex;
	wire [`ARGB_W-1:0]       palEntry;

	always @* begin
		case (stFormat_q)
			`FMT_NIBBLE_INDEX_HIGH_ALPHA: palIndex = {{`NIB_W{1'b0}}, nibLo};
			`FMT_NIBBLE_INDEX_LOW_ALPHA:  palIndex = {{`NIB_W{1'b0}}, nibHi};
			`FMT_BYTE_INDEX_HIGH_ALPHA:   palIndex = byte0;
			`FMT_BYTE_INDEX_LOW_ALPHA:    palIndex = byte1;
			`FMT_BYTE_INDEX_ONLY:         palIndex = byte0;
			`FMT_TWO_BIT_INDEX_ONLY: begin
				palIndex = {{(`PAL_ADDR_W-`TWO_BIT_W){1'b0}}, byte0[`TWO_BIT_W-1:0]};
			end
			default:                      palIndex = {`PAL_ADDR_W{1'b0}};
		endcase
	end

	palette_table #(
		.DEPTH  (PAL_DEPTH),
		.WIDTH  (`ARGB_W),
		.ADDR_W (`PAL_ADDR_W)
	) u_palette (
		.clock       (clock),
		.writeEnable (palWrite),
		.writeAddr   (palAddr),
		.writeData   (palData),
		.readAddr    (palIndex),
		.readData    (palEntry)
	);

	// compressed block: mode from the three top bits
	reg  [`MODE_W-1:0]       blockMode;

	always @* begin
		if (stData_q[`MODE_BIT_HI]) begin
			blockMode = `MODE_SPLIT_PAIR_BLOCK;
		end else if (!stData_q[`MODE_BIT_MID]) begin
			blockMode = `MODE_TWO_COLOUR_INTERP;
		end else if (stData_q[`MODE_BIT_LO]) begin
			blockMode = `MODE_ALPHA_BLOCK;
		end else begin
			blockMode = `MODE_FOUR_COLOUR_DIRECT;
		end
	end

	// texel select positions: 3 bits or 2 bits per texel, texel 0 lowest
	wire [6:0]               selPos3;
	wire [6:0]               selPos2;
	wire [`SEL3_W-1:0]       sel3;
	wire [`SEL2_W-1:0]       sel2;

	assign selPos3 = ({2'h0, stTexel_q} << 1) + {2'h0, stTexel_q};
	assign selPos2 = {2'h0, stTexel_q} << 1;
	assign sel3    = stData_q[selPos3 +: `SEL3_W];
	assign sel2    = stData_q[selPos2 +: `SEL2_W];

	// per-channel interpolation; the sum never carries into a neighbour
	function [`BYTE_W-1:0] lerp6;
		input [`BYTE_W-1:0] c0;
		input [`BYTE_W-1:0] c1;
		input [`SEL3_W-1:0] k;
		reg   [`INTERP_W-1:0] w1;
		reg   [`INTERP_W-1:0] w0;
		reg   [`INTERP_W-1:0] sum;
		reg   [`INTERP_W-1:0] quo;
		begin
			w1    = {{(`INTERP_W-`SEL3_W){1'b0}}, k};
			w0    = `INTERP_DIV - w1;
			sum   = {3'h0, c0} * w0 + {3'h0, c1} * w1 + `INTERP_ROUND;
			quo   = sum / `INTERP_DIV;
			lerp6 = quo[`BYTE_W-1:0];
		end
	endfunction

	// two-colour mode: widen both base colours, then pick from eight entries
	wire [`RGB_W-1:0]        twoC0;
	wire [`RGB_W-1:0]        twoC1;
	wire [`RGB_W-1:0]        twoMix;
	// four-colour mode: four widened colours packed low to high
	wire [4*`RGB_W-1:0]      fourTab;

	genvar ch;
	genvar cn;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_two
			wire [`CH5_W-1:0] f0;
			wire [`CH5_W-1:0] f1;
			assign f0 = stData_q[`TWO_COLOUR_BASE + ch*`CH5_W +: `CH5_W];
			assign f1 = stData_q[`TWO_COLOUR_BASE + `COLOUR_STRIDE + ch*`CH5_W +: `CH5_W];
			assign twoC0[ch*`BYTE_W +: `BYTE_W] = {f0, f0[`CH5_W-1:2]};
			assign twoC1[ch*`BYTE_W +: `BYTE_W] = {f1, f1[`CH5_W-1:2]};
			assign twoMix[ch*`BYTE_W +: `BYTE_W] =
				lerp6(twoC0[ch*`BYTE_W +: `BYTE_W], twoC1[ch*`BYTE_W +: `BYTE_W], sel3);
		end
		for (cn = 0; cn < 4; cn = cn + 1) begin : g_four
			for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
				wire [`CH5_W-1:0] f;
				assign f = stData_q[`FOUR_COLOUR_BASE + cn*`COLOUR_STRIDE + ch*`CH5_W +: `CH5_W];
				assign fourTab[cn*`RGB_W + ch*`BYTE_W +: `BYTE_W] = {f, f[`CH5_W-1:2]};
			end
		end
	endgenerate

	reg  [`ARGB_W-1:0]       blockColour;
	reg                      blockNeedsExt;

	always @* begin
		blockColour   = `COLOUR_ZERO;
		blockNeedsExt = 1'b0;
		case (blockMode)
			`MODE_TWO_COLOUR_INTERP: begin
				if (sel3 == `SEL_TRANSPARENT) begin
					blockColour = `COLOUR_ZERO;
				end else if (sel3 == `SEL_FIRST) begin
					blockColour = {`ALPHA_OPAQUE, twoC0};
				end else if (sel3 == `SEL_LAST_COLOUR) begin
					blockColour = {`ALPHA_OPAQUE, twoC1};
				end else begin
					blockColour = {`ALPHA_OPAQUE, twoMix};
				end
			end
			`MODE_FOUR_COLOUR_DIRECT: begin
				blockColour = {`ALPHA_OPAQUE, fourTab[sel2*`RGB_W +: `RGB_W]};
			end
			`MODE_ALPHA_BLOCK: begin
				blockNeedsExt = 1'b1;
			end
			`MODE_SPLIT_PAIR_BLOCK: begin
				blockNeedsExt = 1'b1;
			end
			default: begin
				blockNeedsExt = 1'b1;
			end
		endcase
	end

	// per-format colour; output packing is A in the top byte, then R, G, B
	reg  [`ARGB_W-1:0]       texColour;
	reg  [`MODE_W-1:0]       texMode;
	reg                      texNeedsExt;
	reg                      texError;

	always @* begin
		texColour   = `COLOUR_ZERO;
		texMode     = `MODE_TWO_COLOUR_INTERP;
		texNeedsExt = 1'b0;
		texError    = 1'b0;
		case (stFormat_q)
			`FMT_RGBA8: begin
				texColour = {byte3, byte0, byte1, byte2};
			end
			`FMT_I8: begin
				texColour = {byte0, byte0, byte0, byte0};
				texError  = stDest_q;
			end
			`FMT_L8: begin
				texColour = {`ALPHA_OPAQUE, byte0, byte0, byte0};
				texError  = stDest_q;
			end
			`FMT_L8A8: begin
				texColour = {byte1, byte0, byte0, byte0};
				texError  = stDest_q;
			end
			`FMT_NIBBLE_INDEX_HIGH_ALPHA: begin
				texColour = {nibHi, nibHi, palEntry[`RGB_W-1:0]};
			end
			`FMT_NIBBLE_INDEX_LOW_ALPHA: begin
				texColour = {nibLo, nibLo, palEntry[`RGB_W-1:0]};
			end
			`FMT_BYTE_INDEX_HIGH_ALPHA: begin
				texColour = {byte1, palEntry[`RGB_W-1:0]};
			end
			`FMT_BYTE_INDEX_LOW_ALPHA: begin
				texColour = {byte0, palEntry[`RGB_W-1:0]};
			end
			`FMT_BYTE_INDEX_ONLY: begin
				texColour = palEntry;
			end
			`FMT_TWO_BIT_INDEX_ONLY: begin
				texColour = palEntry;
			end
			`FMT_BLOCK: begin
				texColour   = blockColour;
				texMode     = blockMode;
				texNeedsExt = blockNeedsExt;
			end
			default: begin
				texError = 1'b1;
			end
		endcase
		// a refused texel carries no colour so filtering cannot blend garbage
		if (texError) begin
			texColour = `COLOUR_ZERO;
		end
	end

	assign fifoInData   = {texError, texNeedsExt, texMode, texColour};
	assign stPush       = stValid_q;
	assign take         = reqValid && reqReady;
	assign fifoOutReady = !outValid || outReady;

	texel_fifo #(
		.WIDTH  (ENTRY_W),
		.DEPTH  (FIFO_DEPTH),
		.ADDR_W (`FIFO_ADDR_W)
	) u_fifo (
		.clock    (clock),
		.reset    (reset),
		.inValid  (stPush),
		.inReady  (fifoInReady),
		.inData   (fifoInData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData),
		.level    (fifoLevel)
	);

	// ready is registered from the fill level; the margin covers the stage
	// slot and the request taken while ready is still stale
	always @(posedge clock) begin
		if (reset) begin
			reqReady   <= 1'b0;
			stValid_q  <= 1'b0;
			stFormat_q <= `FMT_RGBA8;
			stDest_q   <= 1'b0;
			stTexel_q  <= {`TEXEL_IDX_W{1'b0}};
			stData_q   <= {`BLOCK_W{1'b0}};
		end else begin
			reqReady <= (fifoLevel <= READY_LEVEL_MAX);
			if (take) begin
				stValid_q  <= 1'b1;
				stFormat_q <= reqFormat;
				stDest_q   <= reqIsDest;
				stTexel_q  <= reqTexel;
				stData_q   <= reqData;
			end else if (fifoInReady) begin
				stValid_q  <= 1'b0;
			end
		end
	end

	// output register so every port is a flop; stalls hold it steady
	always @(posedge clock) begin
		if (reset) begin
			outValid    <= 1'b0;
			outColor    <= `COLOUR_ZERO;
			outMode     <= `MODE_TWO_COLOUR_INTERP;
			outNeedsExt <= 1'b0;
			outError    <= 1'b0;
		end else if (fifoOutReady) begin
			outValid <= fifoOutValid;
			if (fifoOutValid) begin
				outColor    <= fifoOutData[`ARGB_W-1:0];
				outMode     <= fifoOutData[`ARGB_W +: `MODE_W];
				outNeedsExt <= fifoOutData[`ARGB_W + `MODE_W];
				outError    <= fifoOutData[`ARGB_W + `MODE_W + 1];
			end
		end
	end
endmodule
`default_nettype wire

// ===== core/palette_table.v
// texture palette store: one write port, one combinational read port
// assumes the loader and the decoder share the clock
`timescale 1ns/1ps
`default_nettype none
module palette_table #(
	parameter DEPTH  = 256,
	parameter WIDTH  = 32,
	parameter ADDR_W = 8
) (
	input  wire              clock,
	input  wire              writeEnable,
	input  wire [ADDR_W-1:0] writeAddr,
	input  wire [WIDTH-1:0]  writeData,
	input  wire [ADDR_W-1:0] readAddr,
	output wire [WIDTH-1:0]  readData
);
	reg [WIDTH-1:0] entries [0:DEPTH-1];

	// contents are data, not control, so they are not reset
	always @(posedge clock) begin
		if (writeEnable) begin
			entries[writeAddr] <= writeData;
		end
	end

	assign readData = entries[readAddr];
endmodule
`default_nettype wire

// ===== core/texel_fifo.v
// synchronous fifo with valid/ready on both sides and an occupancy count
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module texel_fifo #(
	parameter WIDTH  = 36,
	parameter DEPTH  = 8,
	parameter ADDR_W = 3
) (
	input  wire              clock,
	input  wire              reset,
	input  wire              inValid,
	output wire              inReady,
	input  wire [WIDTH-1:0]  inData,
	output wire              outValid,
	input  wire              outReady,
	output wire [WIDTH-1:0]  outData,
	output wire [ADDR_W:0]   level
);
	localparam integer      FULL_INT   = DEPTH;
	localparam integer      LAST_INT   = DEPTH - 1;
	localparam [ADDR_W:0]   FULL_COUNT = FULL_INT[ADDR_W:0];
	localparam [ADDR_W-1:0] LAST_SLOT  = LAST_INT[ADDR_W-1:0];

	reg [WIDTH-1:0]  store [0:DEPTH-1];
	reg [ADDR_W-1:0] wrPtr_q;
	reg [ADDR_W-1:0] rdPtr_q;
	reg [ADDR_W:0]   count_q;
	wire             push;
	wire             pop;

	assign inReady  = (count_q != FULL_COUNT);
	assign outValid = (count_q != {(ADDR_W+1){1'b0}});
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = store[rdPtr_q];
	assign level    = count_q;

	always @(posedge clock) begin
		if (push) begin
			store[wrPtr_q] <= inData;
		end
	end

	// pointers wrap at DEPTH so non-power-of-two depths still work
	always @(posedge clock) begin
		if (reset) begin
			wrPtr_q <= {ADDR_W{1'b0}};
			rdPtr_q <= {ADDR_W{1'b0}};
			count_q <= {(ADDR_W+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == LAST_SLOT) ? {ADDR_W{1'b0}} : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == LAST_SLOT) ? {ADDR_W{1'b0}} : rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== shared/texel_decoder_defs.vh
// constants for the texel unpack path: formats, block modes, field positions
// assumes inclusion by every design file of the decoder; definitions only
// Summary of operation
// - stored pixels little endian, low byte first
// - intensity copied into red, green, blue, alpha
// - intensity and luminance rejected as destinations
// - luminance into RGB, alpha field or default
// - high-nibble alpha, low-nibble index, 24-bit entry
// - high-nibble index, low-nibble alpha, nibble replicated
// - high byte alpha, low byte palette index
// - index from high byte, alpha low byte
// - byte index returns full ARGB entry
// - two-bit index returns full ARGB entry
// - block is 128 bits, 32 texels
// - mode chosen from block bits 127..125
// - two-colour field and select positions
// - 5-bit channels widened by top-bit replication
// - entries 0..6 interpolated, alpha opaque
// - entry 7 is transparent black
// - 3-bit select picks one of eight
// - four colours widened, 2-bit select, opaque
// - four-colour fields from 123 down to 64
// - 2-bit selects at 1:0 up 63:62
`ifndef TEXEL_DECODER_DEFS_VH
`define TEXEL_DECODER_DEFS_VH

`define FMT_W                        4
`define FMT_RGBA8                    4'h0
`define FMT_I8                       4'h1
`define FMT_L8                       4'h2
`define FMT_L8A8                     4'h3
`define FMT_NIBBLE_INDEX_HIGH_ALPHA  4'h4
`define FMT_NIBBLE_INDEX_LOW_ALPHA   4'h5
`define FMT_BYTE_INDEX_HIGH_ALPHA    4'h6
`define FMT_BYTE_INDEX_LOW_ALPHA     4'h7
`define FMT_BYTE_INDEX_ONLY          4'h8
`define FMT_TWO_BIT_INDEX_ONLY       4'h9
`define FMT_BLOCK                    4'ha

`define MODE_W                       2
`define MODE_TWO_COLOUR_INTERP       2'h0
`define MODE_FOUR_COLOUR_DIRECT      2'h1
`define MODE_ALPHA_BLOCK             2'h2
`define MODE_SPLIT_PAIR_BLOCK        2'h3

`define BLOCK_W                      128
`define TEXEL_IDX_W                  5
`define MODE_BIT_HI                  127
`define MODE_BIT_MID                 126
`define MODE_BIT_LO                  125

`define BYTE_W                       8
`define NIB_W                        4
`define BYTE0_LO                     0
`define BYTE1_LO                     8
`define BYTE2_LO                     16
`define BYTE3_LO                     24
`define NIB_HI_LO                    4
`define TWO_BIT_W                    2

`define CH5_W                        5
`define COLOUR_STRIDE                15
`define TWO_COLOUR_BASE              96
`define FOUR_COLOUR_BASE             64
`define SEL3_W                       3
`define SEL2_W                       2

`define A_LO                         24
`define R_LO                         16
`define G_LO                         8
`define B_LO                         0
`define ALPHA_OPAQUE                 8'hff
`define COLOUR_ZERO                  32'h00000000
`define RGB_W                        24
`define ARGB_W                       32

`define SEL_FIRST                    3'h0
`define SEL_LAST_COLOUR              3'h6
`define SEL_TRANSPARENT              3'h7
`define INTERP_W                     11
`define INTERP_DIV                   11'h006
`define INTERP_ROUND                 11'h003

`define PAL_DEPTH                    256
`define PAL_ADDR_W                   8
`define FIFO_DEPTH                   8
`define FIFO_ADDR_W                  3
`define READY_MARGIN                 3

`endif

// ===== tb/palette_and_compressed_texel_decoder_tb.sv
// self-checking bench for the texel decoder
// assumes the decoder top, the sink model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "texel_decoder_defs.vh"
module palette_and_compressed_texel_decoder_tb;
	logic         clock = 1'b0;
	logic         reset = 1'b1;
	logic         reqValid = 1'b0;
	logic [3:0]   reqFormat = 4'h0;
	logic         reqIsDest = 1'b0;
	logic [4:0]   reqTexel = 5'h0;
	logic [127:0] reqData = 128'h0;
	logic         palWrite = 1'b0;
	logic [7:0]   palAddr = 8'h0;
	logic [31:0]  palData = 32'h0;
	logic         slow = 1'b0;
	logic         sawFull = 1'b0;
	wire          reqReady, outValid, outReady, outNeedsExt, outError;
	wire [31:0]   outColor;
	wire [1:0]    outMode;
	int           n_fail = 0;
	int           cmp_count = 0;
	logic [35:0]  expQ[$];
	always #20 clock = ~clock;
	palette_and_compressed_texel_decoder palette_and_compressed_texel_decoder_inst (
		.clock(clock), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
		.reqFormat(reqFormat), .reqIsDest(reqIsDest), .reqTexel(reqTexel), .reqData(reqData),
		.palWrite(palWrite), .palAddr(palAddr), .palData(palData), .outValid(outValid),
		.outReady(outReady), .outColor(outColor), .outMode(outMode),
		.outNeedsExt(outNeedsExt), .outError(outError));
	texel_sink_model texel_sink_model_inst (
		.clock(clock), .reset(reset), .slow(slow), .outReady(outReady));
	function automatic [7:0] w5(input [4:0] c);
		w5 = {c, c[4:2]};
	endfunction
	function automatic [7:0] mix(input [7:0] a, input [7:0] b, input [2:0] k);
		int s;
		s = ((6 - k) * a + k * b + 3) / 6;
		mix = s[7:0];
	endfunction
	function automatic [23:0] rgb(input [7:0] i);
		rgb = {i, ~i, i + 8'h31};
	endfunction
	task automatic results;
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic fail(input string m);
		n_fail++;
		$display("Error at %0t: %s", $time, m);
	endtask
	// results come back in request order, so one queue scores them all
	always @(posedge clock) begin
		if (reqValid === 1'b1 && reqReady !== 1'b1)
			sawFull = 1'b1;
		if (outValid === 1'b1 && outReady === 1'b1) begin
			cmp_count++;
			if (expQ.size() == 0)
				fail("unexpected result");
			else if ({outError, outNeedsExt, outMode, outColor} !== expQ.pop_front())
				fail("result mismatch");
		end
	end
	task automatic send(input [3:0] f, input d, input [4:0] t, input [127:0] v, input [35:0] e);
		int i;
		reqValid <= 1'b1;
		reqFormat <= f;
		reqIsDest <= d;
		reqTexel <= t;
		reqData <= v;
		expQ.push_back(e);
		for (i = 0; i < 300; i++) begin
			@(posedge clock);
			if (reqReady === 1'b1)
				break;
		end
		if (i == 300) begin
			fail("request never taken");
			results;
		end
	endtask
	task automatic drain;
		int i;
		reqValid <= 1'b0;
		for (i = 0; i < 3000 && expQ.size() != 0; i++)
			@(posedge clock);
		if (expQ.size() != 0) begin
			fail("results missing");
			results;
		end
	endtask
	task automatic plain_formats;
		send(`FMT_RGBA8, 1'b0, 5'h0, 128'h44332211, {4'h0, 32'h44112233});
		send(`FMT_I8, 1'b0, 5'h0, 128'h5a, {4'h0, 32'h5a5a5a5a});
		send(`FMT_L8, 1'b0, 5'h0, 128'h37, {4'h0, 32'hff373737});
		send(`FMT_L8A8, 1'b0, 5'h0, 128'hc437, {4'h0, 32'hc4373737});
		send(`FMT_I8, 1'b1, 5'h0, 128'h5a, {4'h8, 32'h0});
		send(`FMT_L8, 1'b1, 5'h0, 128'h37, {4'h8, 32'h0});
		send(`FMT_L8A8, 1'b1, 5'h0, 128'hc437, {4'h8, 32'h0});
		send(4'hb, 1'b0, 5'h0, 128'h5a, {4'h8, 32'h0});
		drain;
	endtask
	task automatic palette_formats;
		int i;
		for (i = 0; i < 256; i++) begin
			palWrite <= 1'b1;
			palAddr <= i[7:0];
			palData <= {i[7:0] ^ 8'ha5, rgb(i[7:0])};
			@(posedge clock);
		end
		palWrite <= 1'b0;
		send(`FMT_NIBBLE_INDEX_HIGH_ALPHA, 1'b0, 5'h0, 128'hb6, {12'h0bb, rgb(8'h06)});
		send(`FMT_NIBBLE_INDEX_LOW_ALPHA, 1'b0, 5'h0, 128'hb6, {12'h066, rgb(8'h0b)});
		send(`FMT_BYTE_INDEX_HIGH_ALPHA, 1'b0, 5'h0, 128'hd23c, {12'h0d2, rgb(8'h3c)});
		send(`FMT_BYTE_INDEX_LOW_ALPHA, 1'b0, 5'h0, 128'ha7e1, {12'h0e1, rgb(8'ha7)});
		send(`FMT_BYTE_INDEX_ONLY, 1'b0, 5'h0, 128'h3ca7, {12'h002, rgb(8'ha7)});
		send(`FMT_TWO_BIT_INDEX_ONLY, 1'b0, 5'h0, 128'hfe, {12'h0a7, rgb(8'h02)});
		drain;
	endtask
	task automatic two_colour;
		logic [127:0] blk;
		logic [2:0]   k;
		logic [31:0]  e;
		int           t;
		blk = 128'h0;
		blk[125:96] = {5'h1b, 5'h02, 5'h0d, 5'h04, 5'h1f, 5'h10};
		for (t = 0; t < 32; t++)
			blk[3*t +: 3] = t[2:0] ^ {1'b0, t[4:3]};
		slow <= 1'b1;
		for (t = 0; t < 32; t++) begin
			k = blk[3*t +: 3];
			if (k == 3'h7)
				e = 32'h0;
			else
				e = {8'hff, mix(w5(5'h04), w5(5'h1b), k), mix(w5(5'h1f), w5(5'h02), k),
					mix(w5(5'h10), w5(5'h0d), k)};
			send(`FMT_BLOCK, 1'b0, t[4:0], blk, {4'h0, e});
		end
		drain;
		slow <= 1'b0;
		cmp_count++;
		if (sawFull !== 1'b1)
			fail("fifo never refused a request");
	endtask
	task automatic four_colour;
		logic [14:0]  cols [4] = '{15'h7c1f, 15'h03e0, 15'h5294, 15'h2b6d};
		logic [127:0] blk;
		logic [14:0]  c;
		int           t;
		blk = {3'b010, 1'b1, 124'h0};
		for (t = 0; t < 4; t++)
			blk[64+15*t +: 15] = cols[t];
		for (t = 0; t < 32; t++)
			blk[2*t +: 2] = t[1:0] ^ t[3:2];
		for (t = 0; t < 32; t++) begin
			c = cols[blk[2*t +: 2]];
			send(`FMT_BLOCK, 1'b0, t[4:0], blk,
				{4'h1, 8'hff, w5(c[14:10]), w5(c[9:5]), w5(c[4:0])});
		end
		drain;
	endtask
	task automatic deferred_modes;
		send(`FMT_BLOCK, 1'b0, 5'h3, {3'b011, 125'h0f0f}, {4'h6, 32'h0});
		send(`FMT_BLOCK, 1'b0, 5'h9, {3'b100, 125'h0f0f}, {4'h7, 32'h0});
		send(`FMT_BLOCK, 1'b0, 5'h1f, {3'b111, 125'h3c3c}, {4'h7, 32'h0});
		drain;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		plain_formats;
		palette_formats;
		two_colour;
		four_colour;
		deferred_modes;
		results;
	end
endmodule
`default_nettype wire

// ===== tb/texel_decoder_chk.sv
// checker for the texel decoder's result port
// assumes it is bound to the decoder top and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "texel_decoder_defs.vh"
module texel_decoder_chk (
	input wire logic                 clock,
	input wire logic                 reset,
	input wire logic                 reqValid,
	input wire logic                 reqReady,
	input wire logic [`FMT_W-1:0]    reqFormat,
	input wire logic                 reqIsDest,
	input wire logic                 outValid,
	input wire logic                 outReady,
	input wire logic [`ARGB_W-1:0]   outColor,
	input wire logic [`MODE_W-1:0]   outMode,
	input wire logic                 outNeedsExt,
	input wire logic                 outError
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	chk_error_colour_zero: assert property (outValid && outError |-> outColor == 32'h0)
		else $error("refused texel carries a colour");
	chk_error_not_block: assert property (outValid && outError
		|-> outMode == 2'h0 && !outNeedsExt)
		else $error("refused texel reports a block mode");
	chk_dest_refused: assert property (reqValid && reqReady && reqIsDest
		&& reqFormat == `FMT_I8 |-> ##[3:1000] outValid && outError)
		else $error("intensity destination not refused");
	chk_ext_colour_zero: assert property (outValid && outNeedsExt |-> outColor == 32'h0)
		else $error("deferred block carries a colour");
	chk_ext_mode_upper: assert property (outValid && outNeedsExt |-> outMode[1])
		else $error("deferred block with a decoded mode");
	chk_upper_mode_ext: assert property (outValid && outMode[1] |-> outNeedsExt)
		else $error("alpha or split block not deferred");
	chk_direct_opaque: assert property (outValid && outMode == 2'h1
		|-> outColor[31:24] == 8'hff)
		else $error("four-colour texel not opaque");
	chk_result_held: assert property (outValid && !outReady |=> outValid
		&& $stable(outColor) && $stable(outMode) && $stable(outError) && $stable(outNeedsExt))
		else $error("result changed while stalled");
endmodule
bind palette_and_compressed_texel_decoder texel_decoder_chk texel_decoder_chk_inst (
	.clock(clock), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
	.reqFormat(reqFormat), .reqIsDest(reqIsDest), .outValid(outValid), .outReady(outReady),
	.outColor(outColor), .outMode(outMode), .outNeedsExt(outNeedsExt), .outError(outError));
`default_nettype wire

// ===== tb/texel_sink_model.sv
// filter-side consumer of decoded texels
// assumes the bench's clock; slow makes it take one result in four cycles
`timescale 1ns/1ps
`default_nettype none
module texel_sink_model (
	input wire logic  clock,
	input wire logic  reset,
	input wire logic  slow,
	output logic      outReady
);
	logic [1:0] phase_q;
	always @(posedge clock) begin
		if (reset)
			phase_q <= 2'h0;
		else
			phase_q <= phase_q + 2'h1;
	end
	// stalling lets the fifo fill so that request refusal is seen
	assign outReady = !reset && (!slow || phase_q == 2'h3);
endmodule
`default_nettype wire
